// ===== scsi_timing_trigger_capture_tb.sv
// Purpose: self-checking bench of the timing capture block
// Assumes: APB answer timing as handed over; bus model pulses BSY
// Notes: trigger line located from valid count and post length
`timescale 1ns/1ps
module scsi_timing_trigger_capture_tb;
    import scstc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic go = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [7:0] oth = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, irq, er;
    scstc_sig_t ctl, dat;
    int n_mismatch = 0;
    int checked = 0;

    always #12.5 clk = ~clk;

    scstc_top dut (.I_MCLK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCSI_CTL(ctl), .I_SCSI_DAT(dat),
        .O_IRQ(irq));
    scstc_bus_model bus (.i_clk(clk), .i_go(go), .i_oth(oth), .o_ctl(ctl), .o_dat(dat));

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic look(input int l1, input int l2);
        wr(A_SEL, {l2[15:0], l1[15:0]});
    endtask

    // Model of one line word from previous and current samples
    function automatic logic [31:0] line_w(logic [8:0] p, logic [8:0] c, logic t, int d);
        logic [31:0] w;
        w = {23'h0, 9'(d)};
        w[TRIG_BIT] = t;
        for (int i = 0; i < 9; i++) begin
            w[CODE_LO + 2 * i +: 2] = {p[i], p[i] ^ c[i]};
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic run(input logic [1:0] loc, input int post, input logic [15:0] cnt,
                       input logic [31:0] dp, input int k);
        int v, t;
        logic [7:0] r;
        logic [8:0] lo, hi;
        r = 8'($urandom);
        lo = {1'b0, r};
        hi = {1'b1, r};
        oth <= r;
        wr(A_CPAT, {7'h0, hi, 7'h0, 9'h1FF});
        wr(A_CNT, {16'h0, cnt});
        wr(A_DPAT, dp);
        rdc(A_ERR, 32'h0);
        wr(A_CTRL, {29'h0, loc, 1'b1});
        go <= 1'b1;
        v = 0;
        do begin
            apb(1'b0, A_STAT, 32'h0);
            v++;
        end while (rd[2] !== 1'b1 && v < 20000);
        if (v >= 20000) begin
            n_mismatch++;
            conclude();
        end
        chk({30'h0, rd[1:0]}, 32'h2);
        v = int'(rd[31:16]);
        t = v - 1 - post;
        go <= 1'b0;
        look(t, t + 40);
        rdc(A_LKST, 32'h0);
        rdc(A_STAMP, 32'(t / 4));
        rdc(A_WORD, line_w(lo, hi, 1'b1, k));
        rdc(A_DELTA, 32'h0000_000A);
        look(t - 1, t);
        rdc(A_WORD, line_w(lo, lo, 1'b0, k - 1));
        look(t + 1, t + 1);
        rdc(A_WORD, line_w(hi, lo, 1'b0, k));
        rdc(A_DELTA, 32'h0000_0001);
        look(t + 16, t);
        rdc(A_WORD, line_w(lo, hi, 1'b0, k + 1));
        look(v, t);
        rdc(A_LKST, 32'h41);
        rdc(A_WORD, 32'h0);
        look(t, v);
        rdc(A_LKST, 32'h42);
        chk({31'h0, irq}, 32'h1);
        rdc(A_ISTAT, 32'h3);
        wr(A_ISTAT, 32'h3);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] ea[4];
        logic [31:0] ed[4];
        logic [15:0] ee[4];
        ea = '{A_CTRL, A_CNT, A_DPAT, A_CPAT};
        ed = '{32'h6, 32'h10000, 32'h10000, 32'h10000};
        ee = '{E_LOC, E_CNT, E_DAT, E_CTL};
        void'($urandom(32'h7FDC));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        chk({31'h0, irq}, 32'h0);
        rdc(A_CNT, 32'h1);
        rdc(A_CPAT, 32'h0);
        rdc(A_DPAT, 32'h0);
        look(0, 0);
        rdc(A_LKST, 32'hFE);
        apb(1'b0, 8'h34, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        wr(A_IMASK, 32'h4);
        for (int i = 0; i < 4; i++) begin
            wr(A_CNT, 32'h5);
            wr(ea[i], ed[i]);
            rdc(A_ERR, {16'h0, ee[i]});
            rdc(A_CNT, 32'h1);
            rdc(A_CTRL, 32'h0);
            rdc(A_CPAT, 32'h0);
        end
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wr(A_ISTAT, 32'h4);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(A_IMASK, 32'h0);
        wr(A_CTRL, 32'h6);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rdc(A_ISTAT, 32'h4);
        wr(A_ISTAT, 32'h4);
        wr(A_IMASK, 32'h3);
        run(LOC_AFTER, int'(POST_AFT), 16'h2, 32'h0, 2);
        run(LOC_CENTER, int'(POST_CEN), 16'h1, {7'h0, 9'h003, 7'h0, 9'h1FF}, 3);
        run(LOC_BEFORE, int'(POST_BEF), 16'h3, 32'h0, 3);
        // Count zero fires on the very first line of an idle bus
        wr(A_CNT, 32'h0);
        wr(A_CTRL, {29'h0, LOC_AFTER, 1'b1});
        look(0, 0);
        rdc(A_WORD, 32'h0000_2000);
        rdc(A_STAMP, 32'h0);
        conclude();
    end
endmodule // scsi_timing_trigger_capture_tb

// ===== scstc_bus_model.sv
// Purpose: stand-in for the monitored SCSI bus
// Assumes: 1 means asserted; one BSY pulse of one clock every 16 clocks
// Notes: data carries the pulse number from each BSY rise
`timescale 1ns/1ps
module scstc_bus_model
    import scstc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_oth,
    output scstc_pkg::scstc_sig_t o_ctl,
    output scstc_pkg::scstc_sig_t o_dat
);
    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] ph_r;
    logic [7:0] idx_r;

    // Idle bus: terminators leave every line deasserted
    always_ff @(posedge i_clk) begin
        if (!i_go) begin
            ph_r <= 4'h0;
            idx_r <= 8'h00;
            o_ctl <= 9'h000;
            o_dat <= 9'h000;
        end else begin
            ph_r <= ph_r + 4'h1;
            o_ctl <= {ph_r == 4'h4, i_oth};
            if (ph_r == 4'h4) begin
                idx_r <= idx_r + 8'h01;
                o_dat <= {1'b0, idx_r + 8'h01};
            end
        end
    end
endmodule // scstc_bus_model

// ===== scstc_pkg.sv
// Purpose: constants and types of the timing capture block
// Assumes: 40 MHz clock, APB with 32-bit data
// Notes: one aligned word per register
package scstc_pkg;
    localparam int DEPTH = 32768;
    localparam int AW = 15;
    localparam int CLK_NS = 25;
    localparam int SAMPLE_NS = 20;
    localparam int SAMPLE_CYC = (SAMPLE_NS >= CLK_NS) ? SAMPLE_NS / CLK_NS : 1;
    localparam int TS_NS = 100;
    localparam int TS_CYC = (TS_NS >= CLK_NS) ? TS_NS / CLK_NS : 1;
    localparam logic [7:0] SMP_LAST = 8'(SAMPLE_CYC - 1);
    localparam logic [7:0] TS_LAST = 8'(TS_CYC - 1);
    localparam logic [AW-1:0] POST_BEF = AW'(DEPTH * 95 / 100);
    localparam logic [AW-1:0] POST_CEN = AW'(DEPTH / 2);
    localparam logic [AW-1:0] POST_AFT = AW'(DEPTH * 5 / 100);
    localparam logic [15:0] VCNT_FULL = 16'h8000;
    // Register offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_CPAT = 8'h08;
    localparam logic [7:0] A_DPAT = 8'h0C;
    localparam logic [7:0] A_CNT = 8'h10;
    localparam logic [7:0] A_ERR = 8'h14;
    localparam logic [7:0] A_SEL = 8'h18;
    localparam logic [7:0] A_WORD = 8'h1C;
    localparam logic [7:0] A_STAMP = 8'h20;
    localparam logic [7:0] A_DELTA = 8'h24;
    localparam logic [7:0] A_LKST = 8'h28;
    localparam logic [7:0] A_ISTAT = 8'h2C;
    localparam logic [7:0] A_IMASK = 8'h30;
    // Field positions
    localparam int LAUNCH_BIT = 0;
    localparam int LOC_LO = 1;
    localparam int PAT_VAL_LO = 16;
    localparam int CODE_LO = 14;
    localparam int TRIG_BIT = 13;
    // Reset values
    localparam logic [15:0] CNT_DFLT = 16'h0001;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    // Result codes
    localparam logic [15:0] E_LOC = 16'hFFFC;
    localparam logic [15:0] E_CNT = 16'hFFFD;
    localparam logic [15:0] E_DAT = 16'hFFFE;
    localparam logic [15:0] E_CTL = 16'hFFFF;
    localparam logic [7:0] LK_OK = 8'h00;
    localparam logic [7:0] LK_MISS1 = 8'h41;
    localparam logic [7:0] LK_MISS2 = 8'h42;
    localparam logic [7:0] LK_EMPTY = 8'hFE;
    // Interrupt bits
    localparam int IRQ_TRIG = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_ERR = 2;
    typedef logic [8:0] scstc_sig_t;
    typedef enum logic [1:0] {
        LOC_BEFORE = 2'b00, LOC_CENTER = 2'b01, LOC_AFTER = 2'b10
    } scstc_loc_t;
    typedef struct packed {
        logic [8:0] care;
        logic [8:0] val;
    } scstc_pat_t;
    localparam scstc_pat_t PAT_DFLT = 18'h00000;
    typedef enum logic [1:0] {
        LK_IDLE = 2'b00, LK_RD1 = 2'b01, LK_RD2 = 2'b10, LK_FIN = 2'b11
    } scstc_lk_t;
endpackage

// ===== scstc_top.sv
// Purpose: timing capture and trigger of a passive SCSI bus monitor
// Assumes: control bit 8 is BSY down to bit 0 RST; data bit 8 is DP0
// Notes: inputs are 1 when asserted; registers on APB
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module scstc_top (
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire scstc_pkg::scstc_sig_t I_SCSI_CTL,
    input wire scstc_pkg::scstc_sig_t I_SCSI_DAT,
    output logic O_IRQ
);
    import scstc_pkg::*;

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);

    ////////////////////////////////////////////////////////////////
    // Input synchronisers and previous sample
    scstc_sig_t ctl_m_r, ctl_s_r, ctl_p_r, dat_m_r, dat_s_r;
    logic smp_en;
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctl_m_r <= '0;
            ctl_s_r <= '0;
            ctl_p_r <= '0;
            dat_m_r <= '0;
            dat_s_r <= '0;
        end else begin
            ctl_m_r <= I_SCSI_CTL;
            ctl_s_r <= ctl_m_r;
            dat_m_r <= I_SCSI_DAT;
            dat_s_r <= dat_m_r;
            if (smp_en) ctl_p_r <= ctl_s_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sample and time stamp dividers
    logic [7:0] smp_div_r, ts_div_r;
    logic ts_tick, launch;
    assign smp_en = (smp_div_r == SMP_LAST);
    assign ts_tick = (ts_div_r == TS_LAST);
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            smp_div_r <= 8'h00;
            ts_div_r <= 8'h00;
        end else begin
            smp_div_r <= smp_en ? 8'h00 : smp_div_r + 8'h01;
            ts_div_r <= (ts_tick || launch) ? 8'h00 : ts_div_r + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    // APB decode
    logic pready_r, busy;
    logic acc, wr;
    logic w_ctrl, w_cpat, w_dpat, w_cnt, w_sel, w_istat, w_imask;
    logic bad_loc, bad_cnt, bad_dat, bad_ctl, any_bad;
    scstc_pat_t wpat;
    assign acc = I_PSEL && I_PENABLE && !pready_r && !busy;
    assign wr = acc && I_PWRITE;
    assign w_ctrl = wr && (I_PADDR == A_CTRL);
    assign w_cpat = wr && (I_PADDR == A_CPAT);
    assign w_dpat = wr && (I_PADDR == A_DPAT);
    assign w_cnt = wr && (I_PADDR == A_CNT);
    assign w_sel = wr && (I_PADDR == A_SEL);
    assign w_istat = wr && (I_PADDR == A_ISTAT);
    assign w_imask = wr && (I_PADDR == A_IMASK);
    assign wpat = {I_PWDATA[8:0], I_PWDATA[PAT_VAL_LO+8:PAT_VAL_LO]};
    assign bad_loc = w_ctrl && (I_PWDATA[LOC_LO+1:LOC_LO] == 2'b11);
    assign bad_cnt = w_cnt && (|I_PWDATA[31:16]);
    assign bad_dat = w_dpat && (|(wpat.val & ~wpat.care));
    assign bad_ctl = w_cpat && (|(wpat.val & ~wpat.care));
    assign any_bad = bad_loc || bad_cnt || bad_dat || bad_ctl;
    assign launch = w_ctrl && I_PWDATA[LAUNCH_BIT] && !bad_loc;

    ////////////////////////////////////////////////////////////////
    // Trigger configuration
    scstc_loc_t loc_r;
    scstc_pat_t cpat_r, dpat_r;
    logic [15:0] cnt_cfg_r, err_r;
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            loc_r <= LOC_BEFORE;
            cpat_r <= PAT_DFLT;
            dpat_r <= PAT_DFLT;
            cnt_cfg_r <= CNT_DFLT;
            err_r <= ERR_NONE;
        end else if (any_bad) begin
            loc_r <= LOC_BEFORE;
            cpat_r <= PAT_DFLT;
            dpat_r <= PAT_DFLT;
            cnt_cfg_r <= CNT_DFLT;
            err_r <= bad_loc ? E_LOC : bad_cnt ? E_CNT : bad_dat ? E_DAT : E_CTL;
        end else begin
            if (w_ctrl) loc_r <= scstc_loc_t'(I_PWDATA[LOC_LO+1:LOC_LO]);
            if (w_cpat) cpat_r <= wpat;
            if (w_dpat) dpat_r <= wpat;
            if (w_cnt) cnt_cfg_r <= I_PWDATA[15:0];
            if (w_ctrl || w_cpat || w_dpat || w_cnt) err_r <= ERR_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pattern match, trigger and line word
    logic ctl_hit, dat_hit, match, we, fire;
    logic [15:0] cnt_nxt;
    logic [17:0] codes;
    logic [31:0] line_w;
    logic run_r, trig_done_r, done_r, full_r;
    logic [AW-1:0] wr_ptr_r, post_rem_r, post_len;
    logic [15:0] match_cnt_r;
    logic [31:0] ts_r;
    assign ctl_hit = &(~cpat_r.care | ~(ctl_s_r ^ cpat_r.val));
    assign dat_hit = &(~dpat_r.care | ~(dat_s_r ^ dpat_r.val));
    assign match = ctl_hit && dat_hit;
    assign we = run_r && smp_en && !launch;
    assign cnt_nxt = match_cnt_r + 16'h0001;
    assign fire = we && !trig_done_r &&
        ((cnt_cfg_r == 16'h0000) || (match && (cnt_nxt == cnt_cfg_r)));
    assign post_len = (loc_r == LOC_CENTER) ? POST_CEN :
        (loc_r == LOC_AFTER) ? POST_AFT : POST_BEF;
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_code
            assign codes[2*gi+1] = ctl_p_r[gi];
            assign codes[2*gi] = ctl_p_r[gi] ^ ctl_s_r[gi];
        end
    endgenerate
    assign line_w = {codes, fire, 4'h0, dat_s_r};

    ////////////////////////////////////////////////////////////////
    // Capture control
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            run_r <= 1'b0;
            trig_done_r <= 1'b0;
            done_r <= 1'b0;
            full_r <= 1'b0;
            wr_ptr_r <= '0;
            post_rem_r <= '0;
            match_cnt_r <= 16'h0000;
        end else if (launch) begin
            run_r <= 1'b1;
            trig_done_r <= 1'b0;
            done_r <= 1'b0;
            full_r <= 1'b0;
            wr_ptr_r <= '0;
            match_cnt_r <= 16'h0000;
        end else if (we) begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
            if (&wr_ptr_r) full_r <= 1'b1;
            if (match && !trig_done_r) match_cnt_r <= cnt_nxt;
            if (fire) begin
                trig_done_r <= 1'b1;
                post_rem_r <= post_len;
            end else if (trig_done_r) begin
                post_rem_r <= post_rem_r - AW'(1);
                if (post_rem_r == AW'(1)) begin
                    run_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) ts_r <= 32'h0000_0000;
        else if (launch) ts_r <= 32'h0000_0000;
        else if (run_r && ts_tick) ts_r <= ts_r + 32'h0000_0001;
    end

    ////////////////////////////////////////////////////////////////
    // Capture memories
    logic [31:0] line_mem [DEPTH];
    logic [31:0] ts_mem [DEPTH];
    logic [31:0] rd_word, rd_ts;
    logic [AW-1:0] a1, a2, base, ts_ra;
    scstc_lk_t lk_st_r;
    logic [31:0] sel_r;
    always_ff @(posedge I_MCLK) begin
        if (we) begin
            line_mem[wr_ptr_r] <= line_w;
            ts_mem[wr_ptr_r] <= ts_r;
        end
        rd_word <= line_mem[a1];
        rd_ts <= ts_mem[ts_ra];
    end

    ////////////////////////////////////////////////////////////////
    // Line lookup
    logic [15:0] vcnt;
    logic f1, f2;
    logic [31:0] res_word_r, res_ts_r, delta_r, diff;
    logic [7:0] lk_code_r, code_nxt;
    assign vcnt = full_r ? VCNT_FULL : {1'b0, wr_ptr_r};
    assign base = full_r ? wr_ptr_r : '0;
    assign a1 = base + sel_r[AW-1:0];
    assign a2 = base + sel_r[16+AW-1:16];
    assign ts_ra = (lk_st_r == LK_RD2) ? a2 : a1;
    assign f1 = sel_r[15:0] < vcnt;
    assign f2 = sel_r[31:16] < vcnt;
    assign busy = (lk_st_r != LK_IDLE);
    assign code_nxt = (vcnt == 16'h0000) ? LK_EMPTY :
        !f1 ? LK_MISS1 : !f2 ? LK_MISS2 : LK_OK;
    assign diff = (res_ts_r > rd_ts) ? res_ts_r - rd_ts : rd_ts - res_ts_r;
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            lk_st_r <= LK_IDLE;
            sel_r <= 32'h0000_0000;
            res_word_r <= 32'h0000_0000;
            res_ts_r <= 32'h0000_0000;
            delta_r <= 32'h0000_0000;
            lk_code_r <= LK_OK;
        end else begin
            case (lk_st_r)
                LK_IDLE: begin
                    if (w_sel) begin
                        sel_r <= I_PWDATA;
                        lk_st_r <= LK_RD1;
                    end
                end
                LK_RD1: lk_st_r <= LK_RD2;
                LK_RD2: begin
                    res_word_r <= f1 ? rd_word : 32'h0000_0000;
                    res_ts_r <= f1 ? rd_ts : 32'h0000_0000;
                    lk_st_r <= LK_FIN;
                end
                LK_FIN: begin
                    lk_code_r <= code_nxt;
                    if (code_nxt != LK_OK) delta_r <= 32'h0000_0000;
                    else delta_r <= (diff == 32'h0) ? 32'h1 : diff;
                    lk_st_r <= LK_IDLE;
                end
                default: lk_st_r <= LK_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Interrupts
    logic [2:0] istat_r, imask_r, ev, iclr;
    logic stop_ev, irq_r;
    assign stop_ev = we && trig_done_r && !fire && (post_rem_r == AW'(1));
    assign ev = {any_bad, stop_ev, fire};
    assign iclr = w_istat ? I_PWDATA[2:0] : 3'h0;
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            istat_r <= 3'h0;
            imask_r <= 3'h0;
            irq_r <= 1'b0;
        end else begin
            istat_r <= (istat_r & ~iclr) | ev;
            if (w_imask) imask_r <= I_PWDATA[2:0];
            irq_r <= |(istat_r & imask_r);
        end
    end
    assign O_IRQ = irq_r;

    ////////////////////////////////////////////////////////////////
    // APB read and answer
    logic [31:0] rd_mux, stat_w, prdata_r;
    logic hit, pslverr_r;
    assign stat_w = {vcnt, 10'h000, busy, (vcnt == 16'h0000), full_r, done_r,
        trig_done_r, run_r};
    assign hit = (I_PADDR <= A_IMASK) && (I_PADDR[1:0] == 2'b00);
    assign rd_mux =
        (I_PADDR == A_CTRL) ? {29'h0, loc_r, 1'b0} :
        (I_PADDR == A_STAT) ? stat_w :
        (I_PADDR == A_CPAT) ? {7'h0, cpat_r.val, 7'h0, cpat_r.care} :
        (I_PADDR == A_DPAT) ? {7'h0, dpat_r.val, 7'h0, dpat_r.care} :
        (I_PADDR == A_CNT) ? {16'h0, cnt_cfg_r} :
        (I_PADDR == A_ERR) ? {16'h0, err_r} :
        (I_PADDR == A_SEL) ? sel_r :
        (I_PADDR == A_WORD) ? res_word_r :
        (I_PADDR == A_STAMP) ? res_ts_r :
        (I_PADDR == A_DELTA) ? delta_r :
        (I_PADDR == A_LKST) ? {24'h0, lk_code_r} :
        (I_PADDR == A_ISTAT) ? {29'h0, istat_r} :
        (I_PADDR == A_IMASK) ? {29'h0, imask_r} : 32'h0000_0000;
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc && !hit;
            if (acc) prdata_r <= I_PWRITE ? 32'h0000_0000 : rd_mux;
        end
    end
    assign O_PREADY = pready_r;
    assign O_PSLVERR = pslverr_r;
    assign O_PRDATA = prdata_r;

    ////////////////////////////////////////////////////////////////
    // Assertions
    ctl_match_a: assert property (match |-> ((ctl_s_r & cpat_r.care) == cpat_r.val))
        else $error("control match ignores pattern");
    dat_match_a: assert property (match |-> ((dat_s_r & dpat_r.care) == dpat_r.val))
        else $error("data match ignores pattern");
    cnt_fire_a: assert property (fire && cnt_cfg_r != 16'h0 |-> match && cnt_nxt == cnt_cfg_r)
        else $error("trigger fired at wrong count");
    trig_once_a: assert property (trig_done_r && !launch |=> !fire)
        else $error("second trigger in capture");
    code_pair_a: assert property (we && $past(smp_en) && !$past(launch) |->
        line_w[31] == $past(ctl_s_r[8]) && line_w[30] == ($past(ctl_s_r[8]) ^ ctl_s_r[8]))
        else $error("BSY code wrong");
    trig_bit_a: assert property (we |-> line_w[TRIG_BIT] == fire)
        else $error("trigger bit wrong");
    data_bits_a: assert property (we |-> line_w[8:0] == $past(I_SCSI_DAT, 2))
        else $error("data bits wrong");
    stamp_step_a: assert property (run_r && ts_tick && !launch |=> ts_r == $past(ts_r) + 32'h1)
        else $error("time stamp did not advance");
    delta_nz_a: assert property (lk_st_r == LK_FIN && code_nxt == LK_OK |=> delta_r != 32'h0)
        else $error("zero delta on success");
    bad_dflt_a: assert property (any_bad |=> cpat_r == PAT_DFLT && dpat_r == PAT_DFLT
        && cnt_cfg_r == CNT_DFLT && err_r[15:2] == 14'h3FFF)
        else $error("defaults not restored");
    empty_code_a: assert property (lk_st_r == LK_FIN && vcnt == 16'h0 |=> lk_code_r == LK_EMPTY)
        else $error("empty not reported");
    post_stop_a: assert property (stop_ev && !launch |=> !run_r && done_r)
        else $error("capture did not stop");
    post_load_a: assert property (fire && !launch |=> post_rem_r == $past(post_len))
        else $error("post count not loaded");
endmodule // scstc_top
